// >>> pmc_ctrl.sv
`timescale 1ns/1ps
module pmc_ctrl
	import pmc_pkg::*;
#(
	parameter int OSC_TIMER_W = 14 // Start-up timer width
)
(
	input wire logic core_clk, // 40 MHz clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic clk_en, // Freezes all state when low
	input wire logic [1:0] avs_address, // Word address
	input wire logic avs_read, // Read strobe
	input wire logic avs_write, // Write strobe
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic cpu_wait, // WAIT instruction executed, pulse
	input wire logic wake_event, // Wake-up event, pulse
	input wire logic irq_ack, // Interrupt acknowledge cycle, pulse
	input wire logic slow_xtal_present, // Slow crystal fitted
	input wire logic slow_src_xtal, // Slow clock programmed from crystal
	input wire logic slow_osc_stable, // Slow oscillator good
	output pmc_clkctl_t clkctl, // Clock gating controls
	output logic main_osc_stable, // Fast oscillator good
	output logic wake_pending, // Latched wake-up
	output pmc_mode_t mode // Current mode
);

	// ****************************************
	// State
	// ****************************************
	pmc_mode_t mode_r; // Mode register
	logic psm_r; // Power save select bit
	logic dhf_r; // Fast oscillator disable bit
	logic idle_r; // Idle select bit
	logic halt_r; // Halt select bit
	logic defer_r; // Defer to wait bit
	logic sgood_r; // Sampled slow-good flag
	logic [OSC_TIMER_W-1:0] osc_tmr_r; // Oscillator start-up timer
	logic osc_stop_r; // Oscillator stop command
	logic wake_r; // Latched wake-up
	logic ack_r; // Bus answer phase
	logic [31:0] rdata_r; // Read data register
	pmc_clkctl_t clk_r; // Registered clock controls

	// Decoded helpers
	logic wr_csr; // Write to control word
	logic [7:0] wdat; // Byte written
	logic fgood; // Fast clock good
	logic wake_now; // Wake-up seen this cycle

	// Combine a register byte from fields
	function automatic logic [7:0] csr_byte(input logic sg, input logic fg, input logic df,
		input logic h, input logic i, input logic d, input logic p);
		csr_byte = {sg, fg, df, 1'b0, h, i, d, p};
	endfunction

	// Writes land in the answer cycle, at the edge where waitrequest is low
	assign wr_csr = avs_write && ack_r && (avs_address == PMC_ADDR_CSR);
	assign wdat = avs_writedata[7:0];
	assign fgood = (osc_tmr_r == '0) && !osc_stop_r;
	assign wake_now = wake_event && (mode_r != PMC_ACTIVE);

	// ****************************************
	// Bus slave
	// ****************************************
	// One wait cycle on every access keeps readdata registered
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			ack_r <= 1'b0;
		end
		else if (clk_en)
		begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	// Read data capture, unmapped words read zero
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			rdata_r <= '0;
		end
		else if (clk_en && avs_read && !ack_r)
		begin
			case (avs_address)
				PMC_ADDR_CSR:
					rdata_r <= {24'h0, csr_byte(sgood_r, fgood, defer_r, halt_r, idle_r,
						dhf_r, psm_r)};
				PMC_ADDR_STAT:
					rdata_r <= {29'h0, mode_r};
				PMC_ADDR_EVT:
					rdata_r <= {31'h0, wake_r};
				default:
					rdata_r <= '0;
			endcase
		end
	end

	// ****************************************
	// Slow clock good sampling
	// ****************************************
	// Mux of both good signals, sampled to avoid glitches on source change
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			sgood_r <= 1'b0;
		end
		else if (clk_en)
		begin
			sgood_r <= slow_src_xtal ? slow_osc_stable : fgood;
		end
	end

	// ****************************************
	// Wake-up latch
	// ****************************************
	// Set wins over acknowledge so an event is never lost
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wake_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wake_event)
			begin
				wake_r <= 1'b1;
			end
			else if (irq_ack || (avs_write && ack_r && avs_address == PMC_ADDR_EVT
				&& avs_writedata[0]))
			begin
				wake_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control bits
	// ****************************************
	// Wake-up clears selects; POWER_SAVE_SELECT readback follows the mode when not deferred
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			{defer_r, halt_r, idle_r, dhf_r, psm_r} <= 5'h00;
		end
		else if (clk_en)
		begin
			if (wake_now)
			begin
				psm_r <= 1'b0;
				idle_r <= 1'b0;
				halt_r <= 1'b0;
				dhf_r <= 1'b0;
			end
			else
			begin
				if (wr_csr)
				begin
					dhf_r <= wdat[PMC_BIT_DHF];
					idle_r <= wdat[PMC_BIT_IDLE];
					halt_r <= wdat[PMC_BIT_HALT];
					defer_r <= wdat[PMC_BIT_DEFER];
					// Deferred writes show at once in Active, either value
					if (wdat[PMC_BIT_DEFER] && mode_r == PMC_ACTIVE)
					begin
						psm_r <= wdat[PMC_BIT_PSM];
					end
				end
				// Readback of POWER_SAVE_SELECT tracks completion of immediate switches
				if (mode_r == PMC_PSAVE && !(wr_csr && !wdat[PMC_BIT_PSM]))
				begin
					psm_r <= 1'b1;
				end
				if (mode_r == PMC_ACTIVE && !defer_r && !(wr_csr && wdat[PMC_BIT_DEFER]))
				begin
					psm_r <= 1'b0;
				end
			end
		end
	end

	// Pending immediate request, kept apart from readback
	logic save_req_r; // Immediate power save request
	logic exit_req_r; // Software return to Active request
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			save_req_r <= 1'b0;
			exit_req_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wake_now || mode_r != PMC_ACTIVE)
			begin
				save_req_r <= 1'b0;
			end
			else if (wr_csr)
			begin
				save_req_r <= wdat[PMC_BIT_PSM] && !wdat[PMC_BIT_DEFER];
			end
			if (mode_r != PMC_PSAVE || wake_now)
			begin
				exit_req_r <= 1'b0;
			end
			else if (wr_csr && !wdat[PMC_BIT_PSM])
			begin
				exit_req_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// Mode sequencer
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mode_r <= PMC_ACTIVE;
		end
		else if (clk_en)
		begin
			case (mode_r)
				PMC_ACTIVE:
				begin
					if (cpu_wait && defer_r && halt_r)
					begin
						mode_r <= PMC_HALT;
					end
					else if (cpu_wait && defer_r && idle_r && sgood_r)
					begin
						mode_r <= PMC_IDLE;
					end
					else if (cpu_wait && defer_r && psm_r && sgood_r)
					begin
						mode_r <= PMC_PSAVE;
					end
					else if (save_req_r && sgood_r)
					begin
						mode_r <= PMC_PSAVE;
					end
				end
				PMC_PSAVE:
				begin
					if (wake_event || exit_req_r)
					begin
						mode_r <= PMC_WAKE;
					end
					else if (cpu_wait && halt_r)
					begin
						mode_r <= PMC_HALT;
					end
					else if (cpu_wait && idle_r)
					begin
						mode_r <= PMC_IDLE;
					end
				end
				PMC_IDLE, PMC_HALT:
				begin
					if (wake_event)
					begin
						mode_r <= PMC_WAKE;
					end
				end
				PMC_WAKE:
				begin
					if (fgood)
					begin
						mode_r <= PMC_ACTIVE;
					end
				end
				default:
				begin
					mode_r <= PMC_ACTIVE;
				end
			endcase
		end
	end

	// ****************************************
	// Fast oscillator stop and start-up timer
	// ****************************************
	// Stop only once inside a low-power mode; no crystal means Halt only
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			osc_stop_r <= 1'b0;
		end
		else if (clk_en)
		begin
			case (mode_r)
				PMC_HALT:
					osc_stop_r <= !wake_event;
				PMC_PSAVE, PMC_IDLE:
					osc_stop_r <= dhf_r && slow_xtal_present && !wake_event;
				default:
					osc_stop_r <= 1'b0;
			endcase
		end
	end

	// Preset while stopped, count down to zero after release
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			osc_tmr_r <= OSC_TIMER_W'(PMC_OSC_PRESET);
		end
		else if (clk_en)
		begin
			if (osc_stop_r)
			begin
				osc_tmr_r <= OSC_TIMER_W'(PMC_OSC_PRESET);
			end
			else if (osc_tmr_r != '0)
			begin
				osc_tmr_r <= osc_tmr_r - 1'b1;
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			clk_r <= '0;
			main_osc_stable <= 1'b0;
		end
		else if (clk_en)
		begin
			clk_r.fast_osc_stop <= osc_stop_r;
			clk_r.core_on_slow <= (mode_r == PMC_PSAVE);
			clk_r.core_clk_gate <= (mode_r == PMC_IDLE) || (mode_r == PMC_HALT);
			clk_r.slow_clk_gate <= (mode_r == PMC_HALT);
			main_osc_stable <= fgood;
		end
	end

	assign clkctl = clk_r;
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign wake_pending = wake_r;
	assign mode = mode_r;

	// ****************************************
	// Checks
	// ****************************************
	property p_reg_top;
		@(posedge core_clk) disable iff (!nrst)
		(clk_en && avs_read && !ack_r && avs_address == PMC_ADDR_CSR)
		|=> (rdata_r[PMC_BIT_FGOOD] == $past(fgood) && rdata_r[4] == 1'b0);
	endproperty
	a_reg_top: assert property (p_reg_top) else $error("status bits wrong");

	property p_wake_clear;
		@(posedge core_clk) disable iff (!nrst)
		(clk_en && wake_now) |=> (!psm_r && !idle_r && !halt_r && !dhf_r);
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");

	property p_active_good;
		@(posedge core_clk) disable iff (!nrst)
		(mode_r == PMC_WAKE) ##1 (mode_r == PMC_ACTIVE) |-> $past(fgood);
	endproperty
	a_active_good: assert property (p_active_good) else $error("active without clock");

	property p_save_good;
		@(posedge core_clk) disable iff (!nrst)
		(mode_r == PMC_ACTIVE) ##1 (mode_r == PMC_PSAVE || mode_r == PMC_IDLE)
		|-> $past(sgood_r);
	endproperty
	a_save_good: assert property (p_save_good) else $error("save without slow clock");

	property p_halt_osc;
		@(posedge core_clk) disable iff (!nrst)
		(clk_en && mode_r == PMC_HALT && !wake_event) |=> osc_stop_r;
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("osc running in halt");

	property p_timer;
		@(posedge core_clk) disable iff (!nrst)
		(clk_en && osc_stop_r) |=> (osc_tmr_r == OSC_TIMER_W'(PMC_OSC_PRESET));
	endproperty
	a_timer: assert property (p_timer) else $error("timer not preset");

	property p_nocrystal;
		@(posedge core_clk) disable iff (!nrst)
		(!slow_xtal_present && mode_r != PMC_HALT) |=> !osc_stop_r || $past(mode_r) == PMC_HALT;
	endproperty
	a_nocrystal: assert property (p_nocrystal) else $error("osc off without crystal");

	property p_halt_prio;
		@(posedge core_clk) disable iff (!nrst)
		(clk_en && mode_r == PMC_ACTIVE && cpu_wait && defer_r && halt_r)
		|=> (mode_r == PMC_HALT);
	endproperty
	a_halt_prio: assert property (p_halt_prio) else $error("halt not taken");

endmodule

// >>> pmc_pkg.sv
package pmc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [1:0] PMC_ADDR_CSR = 2'h0; // Mode control/status word
	localparam logic [1:0] PMC_ADDR_STAT = 2'h1; // Current mode word
	localparam logic [1:0] PMC_ADDR_EVT = 2'h2; // Wake-up latch, write 1 to acknowledge

	// Control/status bit positions
	localparam int PMC_BIT_PSM = 0; // Power save select
	localparam int PMC_BIT_DHF = 1; // Fast oscillator disable
	localparam int PMC_BIT_IDLE = 2; // Idle select
	localparam int PMC_BIT_HALT = 3; // Halt select
	localparam int PMC_BIT_DEFER = 5; // Defer power save to wait
	localparam int PMC_BIT_FGOOD = 6; // Fast clock good
	localparam int PMC_BIT_SGOOD = 7; // Slow clock good
	localparam logic [7:0] PMC_CSR_RESET = 8'h00; // All non-reserved bits cleared
	localparam logic [7:0] PMC_CSR_WMASK = 8'h2F; // Software-writable bits

	// Main oscillator start-up timer
	localparam logic [13:0] PMC_OSC_PRESET = 14'h3FFF; // Preset while stopped

	// ****************************************
	// Modes
	// ****************************************
	typedef enum logic [2:0]
	{
		PMC_ACTIVE = 3'b000, // Full speed
		PMC_PSAVE = 3'b001, // Slow clock
		PMC_IDLE = 3'b010, // Only slow-clock units run
		PMC_HALT = 3'b011, // Everything stopped
		PMC_WAKE = 3'b100 // Waiting for fast clock after wake-up
	} pmc_mode_t;

	// Clock gating outputs travel together
	typedef struct packed
	{
		logic fast_osc_stop; // Stop main oscillator
		logic core_on_slow; // Core clocked from slow clock
		logic core_clk_gate; // Core clock stopped
		logic slow_clk_gate; // Slow clock stopped
	} pmc_clkctl_t;

endpackage

// >>> pmc_far_model.sv
`timescale 1ns/1ps
module pmc_far_model
	import pmc_pkg::*;
#(
	parameter int SLOW_SETTLE = 20 // Slow oscillator start-up, cycles
)
(
	input wire logic core_clk, // Clock
	input wire logic nrst, // Sync reset, active low
	input wire logic [2:0] ev_req, // Bench asks: 0 wait, 1 wake, 2 ack
	output logic cpu_wait, // WAIT executed, pulse
	output logic wake_event, // Wake-up, pulse
	output logic irq_ack, // Acknowledge, pulse
	output logic slow_osc_stable // Slow oscillator good
);
	// ****************************************
	// Event pulses
	// ****************************************
	// Registered copies of ev_req; each pulse lasts as long as its request
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			{irq_ack, wake_event, cpu_wait} <= 3'h0;
		else
			{irq_ack, wake_event, cpu_wait} <= ev_req;
	end

	// ****************************************
	// Slow oscillator start-up
	// ****************************************
	int settle_r; // Cycles since reset
	// Unstable for a while after reset, so software has to poll
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			settle_r <= 0;
		else if (settle_r < SLOW_SETTLE)
			settle_r <= settle_r + 1;
	end
	assign slow_osc_stable = (settle_r >= SLOW_SETTLE);
endmodule

// >>> pmc_ctrl_tb.sv
`timescale 1ns/1ps
module pmc_ctrl_tb
	import pmc_pkg::*;
;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic core_clk = 1'h0; // 40 MHz
	logic nrst = 1'h0; // Reset, active low
	logic clk_en = 1'h1; // Never frozen here
	logic [1:0] avs_address = 2'h0; // Word address
	logic avs_read = 1'h0; // Read strobe
	logic avs_write = 1'h0; // Write strobe
	logic [31:0] avs_writedata = 32'h0; // Write data
	logic [31:0] avs_readdata; // Read data
	logic avs_waitrequest; // Stall
	logic cpu_wait; // From model
	logic wake_event; // From model
	logic irq_ack; // From model
	logic slow_xtal_present = 1'h1; // Crystal fitted at first
	logic slow_src_xtal = 1'h1; // Slow clock from crystal
	logic slow_osc_stable; // From model
	logic [2:0] ev_req = 3'h0; // Pulse requests
	pmc_clkctl_t clkctl; // Gating controls
	logic main_osc_stable; // Fast good
	logic wake_pending; // Latched wake-up
	pmc_mode_t mode; // Current mode
	logic [31:0] rd; // Last read data
	logic [2:0] gates; // Osc stop, core gate, slow gate
	int num_errors = 0; // Mismatches
	int total_checks = 0; // Comparisons
	int i; // Poll counter

	assign gates = {clkctl.fast_osc_stop, clkctl.core_clk_gate, clkctl.slow_clk_gate};

	// Half period of 12.5 ns
	always #12.5 core_clk = ~core_clk;

	// Short timer keeps every oscillator restart brief
	pmc_ctrl #(.OSC_TIMER_W(6)) dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_wait(cpu_wait), .wake_event(wake_event),
		.irq_ack(irq_ack), .slow_xtal_present(slow_xtal_present),
		.slow_src_xtal(slow_src_xtal), .slow_osc_stable(slow_osc_stable), .clkctl(clkctl),
		.main_osc_stable(main_osc_stable), .wake_pending(wake_pending), .mode(mode));

	pmc_far_model far_u (.core_clk(core_clk), .nrst(nrst), .ev_req(ev_req),
		.cpu_wait(cpu_wait), .wake_event(wake_event), .irq_ack(irq_ack),
		.slow_osc_stable(slow_osc_stable));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic fail(input string what);
		num_errors++;
		$display("[ERR] %s expected done seen timeout", what);
		wrap_up();
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		// Case inequality so an unknown never matches
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, d};
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 20);
		if (avs_waitrequest !== 1'h0)
			fail("bus");
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		// Idle edge so the next call never lands in this time step
		@(posedge core_clk);
	endtask

	task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
		bus(1'h0, a, 8'h00);
		chk(what, {24'h0, exp}, rd & 32'hFF);
	endtask

	task automatic mode_chk(input pmc_mode_t m);
		chk("mode", 32'(m), 32'(mode));
	endtask

	task automatic pulse(input int idx);
		ev_req <= 3'h1 << idx;
		@(posedge core_clk);
		ev_req <= 3'h0;
		@(posedge core_clk);
	endtask

	// Select 0 mode reached, 1 fast clock good, 2 fast clock lost
	task automatic wait_for(input int sel, input pmc_mode_t m);
		int n;
		for (n = 0; n < 400; n++)
		begin
			@(posedge core_clk);
			if ((sel == 0 && mode === m) || (sel == 1 && main_osc_stable === 1'h1)
				|| (sel == 2 && main_osc_stable === 1'h0))
				break;
		end
		total_checks++;
		if (n >= 400)
			fail("wait");
	endtask

	// Wake-up, back to Active, then acknowledge
	task automatic wake(input bit osc_was_off);
		pulse(1);
		@(posedge core_clk);
		if (osc_was_off)
			mode_chk(PMC_WAKE);
		wait_for(0, PMC_ACTIVE);
		chk("fast good", 32'h1, 32'(main_osc_stable));
		chk("pending", 32'h1, 32'(wake_pending));
		pulse(2);
		@(posedge core_clk);
		chk("pending clr", 32'h0, 32'(wake_pending));
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (2) @(posedge core_clk);
		nrst <= 1'h1;
		@(posedge core_clk);
		rd_chk("csr rst", PMC_ADDR_CSR, 8'h00);
		mode_chk(PMC_ACTIVE);
		bus(1'h1, PMC_ADDR_CSR, 8'hD0);
		rd_chk("csr ro", PMC_ADDR_CSR, 8'h00);
		rd_chk("unmapped", 2'h3, 8'h00);
		wait_for(1, PMC_ACTIVE);
		for (i = 0; i < 40 && rd[PMC_BIT_SGOOD] !== 1'h1; i++)
			bus(1'h0, PMC_ADDR_CSR, 8'h00);
		rd_chk("csr good", PMC_ADDR_CSR, 8'hC0);
		// Deferred entry with Halt and Idle both chosen
		bus(1'h1, PMC_ADDR_CSR, 8'hFF);
		rd_chk("csr defer", PMC_ADDR_CSR, 8'hEF);
		mode_chk(PMC_ACTIVE);
		pulse(0);
		wait_for(0, PMC_HALT);
		repeat (2) @(posedge core_clk);
		chk("halt gates", 32'h7, 32'(gates));
		rd_chk("stat halt", PMC_ADDR_STAT, 8'h03);
		wake(1'h1);
		rd_chk("csr woke", PMC_ADDR_CSR, 8'hE0);
		// Idle from Active with defer set
		bus(1'h1, PMC_ADDR_CSR, 8'h24);
		pulse(0);
		wait_for(0, PMC_IDLE);
		repeat (2) @(posedge core_clk);
		chk("idle gates", 32'h2, 32'(gates));
		wake(1'h0);
		// Idle without defer must be ignored in Active
		bus(1'h1, PMC_ADDR_CSR, 8'h04);
		pulse(0);
		repeat (4) @(posedge core_clk);
		mode_chk(PMC_ACTIVE);
		// Immediate Power Save, then oscillator off and back
		bus(1'h1, PMC_ADDR_CSR, 8'h01);
		wait_for(0, PMC_PSAVE);
		repeat (2) @(posedge core_clk);
		chk("on slow", 32'h1, 32'(clkctl.core_on_slow));
		rd_chk("csr save", PMC_ADDR_CSR, 8'hC1);
		bus(1'h1, PMC_ADDR_CSR, 8'h03);
		wait_for(2, PMC_PSAVE);
		rd_chk("csr dhf", PMC_ADDR_CSR, 8'h83);
		bus(1'h1, PMC_ADDR_CSR, 8'h01);
		wait_for(1, PMC_PSAVE);
		bus(1'h1, PMC_ADDR_CSR, 8'h00);
		wait_for(0, PMC_ACTIVE);
		rd_chk("csr back", PMC_ADDR_CSR, 8'hC0);
		// No slow crystal: fast oscillator must keep running
		slow_xtal_present <= 1'h0;
		slow_src_xtal <= 1'h0;
		bus(1'h1, PMC_ADDR_CSR, 8'h03);
		wait_for(0, PMC_PSAVE);
		repeat (2) @(posedge core_clk);
		chk("osc kept", 32'h0, 32'(clkctl.fast_osc_stop));
		wake(1'h0);
		// Wake-up latch cleared by software write
		pulse(1);
		rd_chk("evt set", PMC_ADDR_EVT, 8'h01);
		bus(1'h1, PMC_ADDR_EVT, 8'h01);
		rd_chk("evt clr", PMC_ADDR_EVT, 8'h00);
		wrap_up();
	end
endmodule
